/* fflc_flag_stage.sv */
// boundary flag register buffer with selectable stage count
`timescale 1ns/1ps
module fflc_flag_stage #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cond_i,
	input wire logic [1:0] stages_i,
	output logic flag_o
);
	import fflc_pkg::*;

	// ==========================================================
	// tap k is set only after cond_i held k+1 edges, so assertion lags by
	// the stage count while removal always lags one edge
	logic [FFLC_MAX_STAGES-1:0] tap_r;

	genvar gi;
	generate
		for (gi = 0; gi < FFLC_MAX_STAGES; gi++) begin : g_tap
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					tap_r[gi] <= RST_VAL;
				end else if (gi == 0) begin
					tap_r[gi] <= cond_i;
				end else begin
					tap_r[gi] <= tap_r[(gi == 0) ? 0 : gi - 1] & cond_i;
				end
			end
		end
	endgenerate

	always_comb begin
		unique case (stages_i)
			FFLC_STG_DOUBLE: flag_o = tap_r[1];
			FFLC_STG_TRIPLE: flag_o = tap_r[2];
			default: flag_o = tap_r[0];
		endcase
	end

endmodule : fflc_flag_stage

/* fflc_flags.sv */
// fifo word count, status flags and configuration-at-reset logic
//
// Overview of operation
// - straps at reset choose single, double or triple boundary flag stages.
// - only empty and full side flags get extra stages; partial flags unaffected.
// - each added stage delays boundary flag assertion by one more cycle.
// - only the fixed empty/full buffering pairings exist, no independent choice.
// - standard timing thresholds: empty at 0, half at D/2+1, full at D.
// - fall-through: capacity D+1, half, partial and full thresholds shifted up by one word; empty stays at 0.
// - empty offset defaults 31, 63 or 127 by depth until reprogrammed.
// - full offset defaults 31, 63 or 127 by depth until reprogrammed.
// - first_load_select low picks asynchronous partial flags, high synchronous.
// - chain straps 0/0 or 1/1 standard single; 1/0 standard double.
// - read 0, write 1 picks fall-through, triple ready-out, double ready-in.
// - reset clears pointers, word count zero, flags show an empty fifo.
// - synchronous partial flags change only on their own side's edges.
// - asynchronous partial flags assert on one side, clear from the other.
// - writes ignored while full; no store, no pointer move.
`timescale 1ns/1ps
module fflc_flags (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic write_enable_n_i,
	input wire logic read_enable_n_i,
	input wire logic first_load_select_i,
	input wire logic read_chain_in_i,
	input wire logic write_chain_in_i,
	input wire logic empty_offset_load_i,
	input wire logic full_offset_load_i,
	input wire logic [fflc_pkg::FFLC_OFS_W-1:0] offset_data_i,
	output logic write_accept_o,
	output logic read_accept_o,
	output logic [fflc_pkg::FFLC_CNT_W-1:0] word_count_o,
	output logic empty_flag_n_o,
	output logic full_flag_n_o,
	output logic almost_empty_flag_n_o,
	output logic almost_full_flag_n_o,
	output logic half_full_flag_n_o,
	output logic fall_through_timing_o,
	output logic sync_partial_o
);
	import fflc_pkg::*;

	// ==========================================================
	// configuration at reset
	fflc_mode_t mode_r;
	logic sync_partial_r;
	logic [1:0] empty_stages;
	logic [1:0] full_stages;
	logic fall_through;

	// straps are read only while reset is held, so a strap wiggling later
	// cannot change flag timing under traffic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_partial_r <= first_load_select_i;
			if (!read_chain_in_i && write_chain_in_i) begin
				mode_r <= FFLC_FALL_THROUGH;
			end else if (read_chain_in_i && !write_chain_in_i) begin
				mode_r <= FFLC_STD_DOUBLE;
			end else begin
				mode_r <= FFLC_STD_SINGLE;
			end
		end
	end

	// fixed pairings, no per-flag depth selection
	always_comb begin
		unique case (mode_r)
			FFLC_FALL_THROUGH: begin
				empty_stages = FFLC_STG_TRIPLE;
				full_stages = FFLC_STG_DOUBLE;
			end
			FFLC_STD_DOUBLE: begin
				empty_stages = FFLC_STG_DOUBLE;
				full_stages = FFLC_STG_DOUBLE;
			end
			default: begin
				empty_stages = FFLC_STG_SINGLE;
				full_stages = FFLC_STG_SINGLE;
			end
		endcase
	end

	assign fall_through = (mode_r == FFLC_FALL_THROUGH);
	assign fall_through_timing_o = fall_through;
	assign sync_partial_o = sync_partial_r;

	// ==========================================================
	// offset registers
	logic [FFLC_OFS_W-1:0] empty_ofs_r;
	logic [FFLC_OFS_W-1:0] full_ofs_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			empty_ofs_r <= FFLC_OFS_DEFAULT;
		end else if (empty_offset_load_i) begin
			empty_ofs_r <= offset_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			full_ofs_r <= FFLC_OFS_DEFAULT;
		end else if (full_offset_load_i) begin
			full_ofs_r <= offset_data_i;
		end
	end

	// ==========================================================
	// word count
	logic [FFLC_CNT_W-1:0] count_r;
	logic [FFLC_CNT_W-1:0] count_nxt;
	logic [FFLC_CNT_W-1:0] capacity;
	logic is_full;
	logic is_empty;
	logic wr_go;
	logic rd_go;

	assign capacity = fall_through ? FFLC_CAP_FT : FFLC_CAP_STD;
	// admission uses the live count, not the buffered pin, so a slow flag
	// can never let a write overrun or a read underrun
	assign is_full = (count_r == capacity);
	assign is_empty = (count_r == FFLC_CNT_ZERO);
	assign wr_go = !write_enable_n_i && !is_full;
	assign rd_go = !read_enable_n_i && !is_empty;
	assign write_accept_o = wr_go;
	assign read_accept_o = rd_go;

	always_comb begin
		count_nxt = count_r;
		if (wr_go && !rd_go) begin
			count_nxt = count_r + FFLC_CNT_ONE;
		end else if (rd_go && !wr_go) begin
			count_nxt = count_r - FFLC_CNT_ONE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= FFLC_CNT_ZERO;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign word_count_o = count_r;

	// ==========================================================
	// partial flag thresholds
	logic [FFLC_CNT_W-1:0] ae_limit;
	logic [FFLC_CNT_W-1:0] af_limit;
	logic [FFLC_CNT_W-1:0] hf_limit;
	logic [FFLC_CNT_W-1:0] part_count;
	logic ae_cond;
	logic af_cond;
	logic hf_cond;

	// fall-through counts the output register as a word, so each threshold
	// moves up by one
	assign ae_limit = fall_through ? FFLC_CNT_W'(empty_ofs_r) + FFLC_CNT_ONE
		: FFLC_CNT_W'(empty_ofs_r);
	assign af_limit = capacity - FFLC_CNT_W'(full_ofs_r);
	assign hf_limit = fall_through ? FFLC_HALF_FT : FFLC_HALF_STD;

	// asynchronous partial timing follows the count as it moves, synchronous
	// timing waits for the settled count on the following edge
	assign part_count = sync_partial_r ? count_r : count_nxt;
	assign ae_cond = (part_count <= ae_limit);
	assign af_cond = (part_count >= af_limit);
	assign hf_cond = (count_nxt >= hf_limit);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			almost_empty_flag_n_o <= 1'b0;
			almost_full_flag_n_o <= 1'b1;
			half_full_flag_n_o <= 1'b1;
		end else begin
			almost_empty_flag_n_o <= !ae_cond;
			almost_full_flag_n_o <= !af_cond;
			half_full_flag_n_o <= !hf_cond;
		end
	end

	// ==========================================================
	// boundary flags
	logic empty_hit;
	logic full_hit;

	fflc_flag_stage #(
		.RST_VAL(1'b1)
	) u_empty_stage (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cond_i(count_nxt == FFLC_CNT_ZERO),
		.stages_i(empty_stages),
		.flag_o(empty_hit)
	);

	fflc_flag_stage #(
		.RST_VAL(1'b0)
	) u_full_stage (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cond_i(count_nxt == capacity),
		.stages_i(full_stages),
		.flag_o(full_hit)
	);

	// standard pins go low on the boundary; ready pins go high on it
	assign empty_flag_n_o = fall_through ? empty_hit : !empty_hit;
	assign full_flag_n_o = fall_through ? full_hit : !full_hit;

endmodule : fflc_flags

/* fflc_flags_asserts.sv */
// checker on the flag and configuration ports
`timescale 1ns/1ps
module fflc_flags_asserts
	import fflc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic first_load_select_i,
	input wire logic read_chain_in_i,
	input wire logic write_chain_in_i,
	input wire logic write_accept_o,
	input wire logic [fflc_pkg::FFLC_CNT_W-1:0] word_count_o,
	input wire logic empty_flag_n_o,
	input wire logic full_flag_n_o,
	input wire logic almost_empty_flag_n_o,
	input wire logic almost_full_flag_n_o,
	input wire logic half_full_flag_n_o,
	input wire logic fall_through_timing_o,
	input wire logic sync_partial_o
);
	// ====
	// helpers: offsets assumed at default, the bench never reloads them
	logic [13:0] w, cap, ae_t, hf_t;
	logic ft, dbl_r;
	assign w = word_count_o;
	assign ft = fall_through_timing_o;
	assign cap = ft ? FFLC_CAP_FT : FFLC_CAP_STD;
	assign ae_t = {2'h0, FFLC_OFS_DEFAULT} + {13'h0, ft};
	assign hf_t = ft ? FFLC_HALF_FT : FFLC_HALF_STD;
	always_ff @(posedge clk_i) begin
		if (rst_i) dbl_r <= read_chain_in_i & ~write_chain_in_i;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ====
	// properties
	// a refused write must also leave the count at or below capacity next cycle
	AST_WR_FULL: assert property (w == cap |-> !write_accept_o ##1 w <= cap)
		else $error("write taken while full");
	AST_AF_SYNC: assert property (sync_partial_o |=> almost_full_flag_n_o == ($past(w) < cap - 14'h001f))
		else $error("sync almost full wrong");
	AST_HF: assert property (half_full_flag_n_o == (w < hf_t))
		else $error("half flag wrong");
	AST_AE_ASYNC: assert property (!sync_partial_o |-> almost_empty_flag_n_o == (w > ae_t))
		else $error("async almost empty wrong");
	AST_AE_SYNC: assert property (sync_partial_o |=> almost_empty_flag_n_o == ($past(w) > ae_t))
		else $error("sync almost empty wrong");
	AST_AF_ASYNC: assert property (!sync_partial_o |-> almost_full_flag_n_o == (w < cap - 14'h001f))
		else $error("async almost full wrong");
	// a delayed flag still shows negated on the first cycle at the boundary
	AST_FULL_BUF: assert property (w != cap ##1 (w == cap) [*2] |->
		full_flag_n_o == ft && $past(full_flag_n_o) == (ft ^ (ft | dbl_r)))
		else $error("full side buffering wrong");
	AST_OR_TRIPLE: assert property (ft && w != 0 ##1 (w == 0) [*3] |->
		empty_flag_n_o && !$past(empty_flag_n_o) && !$past(empty_flag_n_o, 2))
		else $error("ready out buffering wrong");
	AST_CFG: assert property ($fell(rst_i) |-> ft == $past(!read_chain_in_i && write_chain_in_i)
		&& sync_partial_o == $past(first_load_select_i))
		else $error("strap decode wrong");
	cover property (w == cap);
	cover property (ft && empty_flag_n_o);
	cover property (sync_partial_o && !almost_empty_flag_n_o);
endmodule : fflc_flags_asserts
bind fflc_flags fflc_flags_asserts fflc_flags_asserts_i (.*);

/* fflc_flags_tb.sv */
// self-checking bench for the flag and configuration logic
`timescale 1ns/1ps
module fflc_flags_tb;
	import fflc_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, fl = 1'b0, read_chain_in = 1'b0, write_chain_in = 1'b0;
	logic fill = 1'b0, drain = 1'b0, ft_x = 1'b0, we_n, re_n;
	logic ef_n, ff_n, ae_n, af_n, hf_n, ft, sp;
	logic [13:0] w, exp_w, cap;
	int n_errors = 0, compares = 0;
	initial forever #2 clk_i = ~clk_i;
	fflc_partner fflc_partner_i (.clk_i(clk_i), .fill_i(fill), .drain_i(drain),
		.write_enable_n_o(we_n), .read_enable_n_o(re_n));
	fflc_flags fflc_flags_i (.clk_i(clk_i), .rst_i(rst_i), .write_enable_n_i(we_n),
		.read_enable_n_i(re_n), .first_load_select_i(fl), .read_chain_in_i(read_chain_in),
		.write_chain_in_i(write_chain_in), .empty_offset_load_i(1'b0), .full_offset_load_i(1'b0),
		.offset_data_i(12'h000), .write_accept_o(), .read_accept_o(), .word_count_o(w),
		.empty_flag_n_o(ef_n), .full_flag_n_o(ff_n), .almost_empty_flag_n_o(ae_n),
		.almost_full_flag_n_o(af_n), .half_full_flag_n_o(hf_n),
		.fall_through_timing_o(ft), .sync_partial_o(sp));
	// ====
	// expected word count
	assign cap = ft_x ? 14'h0101 : 14'h0100;
	always @(posedge clk_i) begin
		if (rst_i) exp_w <= 14'h0000;
		else exp_w <= exp_w + {13'h0, !we_n && exp_w != cap} - {13'h0, !re_n && exp_w != 0};
	end
	task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic results();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	task automatic go(input logic [13:0] tgt);
		int k = 0;
		while (w !== tgt && k < 2000) begin
			@(negedge clk_i);
			k++;
		end
		if (k == 2000) begin
			n_errors++;
			results();
		end else begin
			repeat (3) @(negedge clk_i);
		end
	endtask : go
	// ====
	// every cycle: count and half flag, almost flags only with asynchronous partial timing, offsets at their default of 31
	always @(negedge clk_i) begin
		if (!rst_i) begin
			chk("count", w, exp_w);
			chk("half", hf_n, exp_w < (ft_x ? 14'h0082 : 14'h0081));
			if (!fl) chk("almost empty", ae_n, exp_w > 14'h001f + ft_x);
			if (!fl) chk("almost full", af_n, exp_w < cap - 14'h001f);
		end
	end
	initial begin
		void'($urandom(54280));
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_i);
			rst_i = 1'b1;
			{fl, read_chain_in, write_chain_in} = i[2:0];
			ft_x = !read_chain_in && write_chain_in;
			fill = 1'b0;
			drain = 1'b0;
			repeat (6) @(negedge clk_i);
			rst_i = 1'b0;
			chk("timing", ft, ft_x);
			chk("partial", sp, fl);
			chk("empty", ef_n, ft_x);
			fill = 1'b1;
			go(cap);
			chk("full", ff_n, ft_x);
			chk("empty", ef_n, !ft_x);
			fill = 1'b0;
			drain = 1'b1;
			go(14'h0000);
			chk("empty", ef_n, ft_x);
			fill = 1'b1;
			repeat (300) @(negedge clk_i);
		end
		results();
	end
endmodule : fflc_flags_tb

/* fflc_partner.sv */
// writer and reader issuing requests to the fifo
`timescale 1ns/1ps
module fflc_partner (
	input wire logic clk_i,
	input wire logic fill_i,
	input wire logic drain_i,
	output logic write_enable_n_o = 1'b1,
	output logic read_enable_n_o = 1'b1
);
	// ====
	// requests keep coming at full or empty so refusals get exercised
	always @(negedge clk_i) begin
		write_enable_n_o <= !(fill_i && ($urandom % 8 != 0));
		read_enable_n_o <= !(drain_i && ($urandom % 8 != 0));
	end
endmodule : fflc_partner

/* fflc_pkg.sv */
// constants, types and defaults for the fifo flag and configuration logic
package fflc_pkg;

	// ==========================================================
	// geometry
	localparam int FFLC_DEPTH = 256;
	localparam int FFLC_CNT_W = 14;
	localparam int FFLC_OFS_W = 12;
	localparam int FFLC_MAX_STAGES = 3;

	// ==========================================================
	// default offsets by depth
	localparam logic [11:0] FFLC_OFS_D256 = 12'h01f;
	localparam logic [11:0] FFLC_OFS_D512 = 12'h03f;
	localparam logic [11:0] FFLC_OFS_LARGE = 12'h07f;
	localparam logic [11:0] FFLC_OFS_DEFAULT = (FFLC_DEPTH == 256) ? FFLC_OFS_D256 :
		(FFLC_DEPTH == 512) ? FFLC_OFS_D512 : FFLC_OFS_LARGE;

	// ==========================================================
	// count thresholds
	localparam logic [13:0] FFLC_CAP_STD = 14'(FFLC_DEPTH);
	localparam logic [13:0] FFLC_CAP_FT = 14'(FFLC_DEPTH + 1);
	localparam logic [13:0] FFLC_HALF_STD = 14'(FFLC_DEPTH / 2 + 1);
	localparam logic [13:0] FFLC_HALF_FT = 14'(FFLC_DEPTH / 2 + 2);
	localparam logic [13:0] FFLC_CNT_ZERO = 14'h0000;
	localparam logic [13:0] FFLC_CNT_ONE = 14'h0001;

	// ==========================================================
	// buffer stage counts
	localparam logic [1:0] FFLC_STG_SINGLE = 2'h1;
	localparam logic [1:0] FFLC_STG_DOUBLE = 2'h2;
	localparam logic [1:0] FFLC_STG_TRIPLE = 2'h3;

	// ==========================================================
	// the only timing/buffer pairings offered
	typedef enum logic [1:0] {
		FFLC_STD_SINGLE = 2'h0,
		FFLC_STD_DOUBLE = 2'h1,
		FFLC_FALL_THROUGH = 2'h3
	} fflc_mode_t;

endpackage : fflc_pkg
